// [hw/io_host_pkg.sv]
package io_host_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 8;
	localparam int FUSE_HALF_NS = 32;
	localparam int FUSE_HALF_CYC = (FUSE_HALF_NS + CLK_NS - 1) / CLK_NS;
	// ----------------------------------------------------------------
	// register word indices (byte address = index * 4)
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_HDR = 4'h1;
	localparam logic [3:0] REG_PAY0 = 4'h2;
	localparam logic [3:0] REG_PAY3 = 4'h5;
	localparam logic [3:0] REG_FUSE_LO = 4'h6;
	localparam logic [3:0] REG_FUSE_HI = 4'h7;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_CREDITS = 4'h9;
	localparam logic [3:0] REG_PIO_LO = 4'hA;
	localparam logic [3:0] REG_PIO_HI = 4'hB;
	localparam logic [3:0] REG_MMU_LO = 4'hC;
	localparam logic [3:0] REG_MMU_HI = 4'hD;
	// ----------------------------------------------------------------
	// upstream packet link
	// ----------------------------------------------------------------
	localparam logic [2:0] PAY_BEATS = 3'h4;
	localparam int TAG_KIND = 15;
	localparam int TAG_CRED_LO = 8;
	localparam int CRED_W = 4;
	localparam int CREDITS = 16;
	localparam int PIO_CRED_LO = 56;
	localparam logic [31:0] HDR_RSVD_MASK = 32'hF03F_FFFF;
	localparam logic [31:0] HDR_RET_MASK = 32'hFFFF_8FFF;
	localparam logic [31:0] HDR_INT_MASK = 32'hFFFF_FFFF;
	localparam logic [15:0] CRED_ONE = 16'h0001;
	// ----------------------------------------------------------------
	// fuse serial link
	// ----------------------------------------------------------------
	localparam int N_STROBE = 4;
	localparam int FUSE_W = 64;
	localparam logic [1:0] FUSE_STAT_SEL = 2'h3;
	localparam logic [6:0] FUSE_BITS = 7'h16;
	localparam logic [6:0] FUSE_STAT_BITS = 7'h40;
	localparam int FUSE_PAD = FUSE_W - int'(FUSE_BITS);
	// ----------------------------------------------------------------
	// unit control packet codes
	// ----------------------------------------------------------------
	localparam logic [3:0] PT_RD_REJ = 4'h0;
	localparam logic [3:0] PT_RD_ACK = 4'h1;
	localparam logic [3:0] PT_FL_ACK = 4'h3;
	localparam logic [3:0] PT_FL_REJ = 4'h7;
	localparam logic [3:0] PT_RD_REQ = 4'h4;
	localparam logic [3:0] PT_WR_REQ = 4'h5;
	localparam logic [3:0] PT_FL_REQ = 4'h6;
	localparam logic [2:0] SZ_1B = 3'h0;
	localparam logic [2:0] SZ_4B = 3'h2;
	localparam logic [2:0] SZ_8B = 3'h3;
	localparam logic [1:0] BUF_CORE = 2'h0;
	localparam logic [1:0] BUF_TEST = 2'h1;
	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [8:0] byte_sel;
		logic [39:0] addr;
		logic [2:0] size;
		logic [1:0] buf_id;
		logic [2:0] cpu_id;
		logic [2:0] thread_id;
		logic [3:0] ptype;
	} ctl_hdr_s;
	typedef struct packed {
		logic [63:0] payload;
		ctl_hdr_s hdr;
	} ctl_pkt_s;
	typedef struct packed {
		logic read;
		logic write;
		logic [5:0] address;
		logic [31:0] writedata;
	} avl_req_s;
	typedef struct packed {
		logic hdr_valid;
		logic mmu_valid;
		logic [63:0] data;
	} pio_bus_s;
	typedef struct packed {
		logic accept;
		logic reject;
		logic [5:0] id;
	} int_rsp_s;
	typedef struct packed {
		logic [19:0] rsvd_hi;
		logic [1:0] fuse_sel;
		logic [1:0] rsvd_mid;
		logic [3:0] tag;
		logic rsvd_lo;
		logic fuse_go;
		logic wr_done;
		logic send;
	} ctrl_cmd_s;
	typedef struct packed {
		logic [7:0] rsvd_hi;
		logic [7:0] int_count;
		logic [1:0] rsvd_mid;
		logic [5:0] int_id;
		logic [1:0] rsvd_lo;
		logic int_rej;
		logic int_acc;
		logic int_err;
		logic cred_err;
		logic fuse_busy;
		logic up_busy;
	} status_s;
endpackage : io_host_pkg

// [hw/fuse_shifter.sv]
`timescale 1ns/10ps
`default_nettype none
module fuse_shifter (
	// system
	input wire logic clk,
	input wire logic reset_n,
	// command
	input wire logic start,
	input wire logic [1:0] sel,
	input wire logic [63:0] word,
	output var logic busy,
	// serial link
	output var logic fuse_shift_clock,
	output var logic fuse_data,
	output var logic [io_host_pkg::N_STROBE-1:0] fuse_strobe
);
	import io_host_pkg::*;

	logic busy_q;
	logic clk_q;
	logic data_q;
	logic [N_STROBE-1:0] strobe_q;
	logic [63:0] sh_q;
	logic [6:0] cnt_q;
	logic [6:0] len_q;
	logic [7:0] div_q;
	logic [6:0] rises_q;
	logic take;
	logic is_stat;
	logic tick;
	logic last;
	logic first_bit;
	logic [63:0] aligned;

	assign take = start & ~busy_q;
	assign is_stat = (sel == FUSE_STAT_SEL);
	assign tick = busy_q & (div_q == 8'(FUSE_HALF_CYC - 1));
	assign last = tick & clk_q & (cnt_q == 7'h01);
	// 22-bit words sit at the top so every field leaves msb first
	assign aligned = is_stat ? word : {word[FUSE_BITS-1:0], FUSE_PAD'(0)};
	assign first_bit = aligned[FUSE_W-1];
	assign busy = busy_q;
	assign fuse_shift_clock = clk_q;
	assign fuse_data = data_q;
	assign fuse_strobe = strobe_q;

	// ----------------------------------------------------------------
	// bit clock divider
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_q <= 8'h00;
		end else if (!busy_q || tick) begin
			div_q <= 8'h00;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// shifter: data changes on the falling bit clock
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_q <= 1'b0;
			clk_q <= 1'b0;
			data_q <= 1'b0;
			sh_q <= 64'h0;
			cnt_q <= 7'h00;
			len_q <= 7'h00;
		end else if (take) begin
			busy_q <= 1'b1;
			clk_q <= 1'b0;
			sh_q <= aligned;
			data_q <= first_bit;
			cnt_q <= is_stat ? FUSE_STAT_BITS : FUSE_BITS;
			len_q <= is_stat ? FUSE_STAT_BITS : FUSE_BITS;
		end else if (tick) begin
			clk_q <= ~clk_q;
			if (last) begin
				busy_q <= 1'b0;
				data_q <= 1'b0;
			end else if (clk_q) begin
				sh_q <= {sh_q[62:0], 1'b0};
				data_q <= sh_q[62];
				cnt_q <= cnt_q - 7'h01;
			end
		end
	end

	// one strobe per destination, all sharing the data line
	genvar gi;
	generate
		for (gi = 0; gi < N_STROBE; gi++) begin : g_strobe
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					strobe_q[gi] <= 1'b0;
				end else if (take && sel == 2'(gi)) begin
					strobe_q[gi] <= 1'b1;
				end else if (last) begin
					strobe_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rises_q <= 7'h00;
		end else if (take) begin
			rises_q <= 7'h00;
		end else if (tick && !clk_q) begin
			rises_q <= rises_q + 7'h01;
		end
	end

	chk_fuse_bit_count: assert property (@(posedge clk) disable iff (!reset_n)
		$fell(busy_q) |-> rises_q == len_q)
		else $error("fuse word length wrong");
	chk_fuse_msb_first: assert property (@(posedge clk) disable iff (!reset_n)
		take |=> fuse_data == $past(first_bit) && !fuse_shift_clock)
		else $error("fuse word not msb first");
	chk_fuse_one_strobe: assert property (@(posedge clk) disable iff (!reset_n)
		$onehot0(strobe_q) && (busy_q == (|strobe_q)))
		else $error("fuse strobe not single");
endmodule : fuse_shifter
`default_nettype wire

// [hw/io_host_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
module io_host_ctrl (
	// system
	input wire logic clk,
	input wire logic reset_n,
	// register bus
	input wire io_host_pkg::avl_req_s avl,
	output var logic [31:0] avl_readdata,
	output var logic avl_waitrequest,
	// upstream packet link
	output var logic up_req,
	input wire logic up_grant,
	output var logic up_valid,
	output var logic [31:0] up_data,
	// request path from device
	input wire io_host_pkg::pio_bus_s pio,
	output var logic wr_done_valid,
	output var logic [3:0] wr_done_tag,
	// interrupt response from device
	input wire io_host_pkg::int_rsp_s int_rsp,
	// fuse link
	output var logic fuse_shift_clock,
	output var logic fuse_data,
	output var logic [io_host_pkg::N_STROBE-1:0] fuse_strobe
);
	import io_host_pkg::*;

	typedef enum logic [1:0] {UP_IDLE, UP_REQ, UP_SEND} up_st_e;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic wait_q;
	logic [31:0] rdata_q;
	logic [3:0] idx;
	logic acc;
	logic acc_wr;
	logic wr_ctrl;
	logic wr_hdr;
	logic wr_pay;
	logic wr_stat;
	logic [1:0] pay_sel;
	ctrl_cmd_s cmd;
	status_s wstat;
	logic [15:0][31:0] rmap;
	logic up_busy;

	assign idx = avl.address[5:2];
	assign acc = (avl.read | avl.write) & ~wait_q;
	assign acc_wr = acc & avl.write;
	assign cmd = ctrl_cmd_s'(avl.writedata);
	assign wstat = status_s'(avl.writedata);
	assign wr_ctrl = acc_wr & (idx == REG_CTRL);
	assign wr_stat = acc_wr & (idx == REG_STATUS);
	assign wr_hdr = acc_wr & (idx == REG_HDR) & ~up_busy;
	assign wr_pay = acc_wr & (idx >= REG_PAY0) & (idx <= REG_PAY3) & ~up_busy;
	assign pay_sel = 2'(idx - REG_PAY0);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	up_st_e st_q;
	logic up_req_q;
	logic up_valid_q;
	logic [31:0] up_data_q;
	logic [2:0] beat_q;
	logic [31:0] hdr_q;
	logic [3:0][31:0] pay_q;
	logic [63:0] fuse_word_q;
	logic [63:0] pio_q;
	logic [63:0] mmu_q;
	logic [15:0] credits_q;
	logic cred_err_q;
	logic int_err_q;
	logic int_acc_q;
	logic int_rej_q;
	logic [5:0] int_id_q;
	logic [7:0] int_count_q;
	logic wr_done_q;
	logic [3:0] wr_tag_q;
	logic fuse_busy;
	status_s stat;

	// ----------------------------------------------------------------
	// packet build
	// ----------------------------------------------------------------
	function automatic ctl_pkt_s pkt_clean(input ctl_pkt_s p);
		ctl_pkt_s r;
		logic ret;
		r = p;
		ret = 1'b0;
		case (p.hdr.ptype)
			PT_RD_REJ, PT_FL_REJ: begin
				r.payload = 64'h0;
				ret = 1'b1;
			end
			PT_RD_ACK, PT_FL_ACK: begin
				ret = 1'b1;
			end
			default: begin
				ret = 1'b0;
			end
		endcase
		if (ret) begin
			r.hdr.addr = 40'h0;
			r.hdr.size = 3'h0;
		end
		// byte select is only meaningful for test-unit packets
		if (p.hdr.buf_id != BUF_TEST) begin
			r.hdr.byte_sel = 9'h000;
		end
		return r;
	endfunction : pkt_clean

	ctl_pkt_s pkt_out;
	logic [3:0][31:0] pkt_w;
	logic [31:0] hdr_out;
	logic is_ret;
	logic [3:0] hdr_cred;

	assign pkt_out = pkt_clean(ctl_pkt_s'(pay_q));
	assign pkt_w = pkt_out;
	assign is_ret = hdr_q[TAG_KIND];
	// reserved bits forced low; read returns keep tag bits 14:12 at zero
	assign hdr_out = hdr_q & HDR_RSVD_MASK & (is_ret ? HDR_RET_MASK : HDR_INT_MASK);
	assign hdr_cred = hdr_q[TAG_CRED_LO +: CRED_W];

	// ----------------------------------------------------------------
	// credit tracking
	// ----------------------------------------------------------------
	logic up_start;
	logic [3:0] pio_cred;
	logic [15:0] set_vec;
	logic [15:0] clr_vec;
	logic cred_clash;

	assign up_start = (st_q == UP_REQ) & up_grant;
	assign pio_cred = pio.data[PIO_CRED_LO +: CRED_W];
	assign set_vec = pio.hdr_valid ? (CRED_ONE << pio_cred) : 16'h0000;
	assign clr_vec = ((wr_ctrl & cmd.wr_done) ? (CRED_ONE << cmd.tag) : 16'h0000)
		| ((up_start & is_ret) ? (CRED_ONE << hdr_cred) : 16'h0000);
	assign cred_clash = |(set_vec & credits_q & ~clr_vec);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			credits_q <= 16'h0000;
		end else begin
			credits_q <= (credits_q & ~clr_vec) | set_vec;
		end
	end

	// ----------------------------------------------------------------
	// register bus slave: one wait cycle, then the answer
	// ----------------------------------------------------------------
	assign stat = '{
		rsvd_hi: 8'h00,
		int_count: int_count_q,
		rsvd_mid: 2'h0,
		int_id: int_id_q,
		rsvd_lo: 2'h0,
		int_rej: int_rej_q,
		int_acc: int_acc_q,
		int_err: int_err_q,
		cred_err: cred_err_q,
		fuse_busy: fuse_busy,
		up_busy: up_busy
	};

	always_comb begin
		rmap = '0;
		rmap[REG_HDR] = hdr_q;
		rmap[REG_PAY0] = pay_q[0];
		rmap[REG_PAY0 + 4'h1] = pay_q[1];
		rmap[REG_PAY0 + 4'h2] = pay_q[2];
		rmap[REG_PAY3] = pay_q[3];
		rmap[REG_FUSE_LO] = fuse_word_q[31:0];
		rmap[REG_FUSE_HI] = fuse_word_q[63:32];
		rmap[REG_STATUS] = stat;
		rmap[REG_CREDITS] = 32'(credits_q);
		rmap[REG_PIO_LO] = pio_q[31:0];
		rmap[REG_PIO_HI] = pio_q[63:32];
		rmap[REG_MMU_LO] = mmu_q[31:0];
		rmap[REG_MMU_HI] = mmu_q[63:32];
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else if ((avl.read | avl.write) && wait_q) begin
			wait_q <= 1'b0;
			rdata_q <= avl.read ? rmap[idx] : 32'h0000_0000;
		end else begin
			wait_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hdr_q <= 32'h0000_0000;
			pay_q <= '0;
			fuse_word_q <= 64'h0;
		end else if (wr_hdr) begin
			hdr_q <= avl.writedata;
		end else if (wr_pay) begin
			pay_q[pay_sel] <= avl.writedata;
		end else if (acc_wr && idx == REG_FUSE_LO) begin
			fuse_word_q[31:0] <= avl.writedata;
		end else if (acc_wr && idx == REG_FUSE_HI) begin
			fuse_word_q[63:32] <= avl.writedata;
		end
	end

	// ----------------------------------------------------------------
	// write-done return toward the device
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_done_q <= 1'b0;
			wr_tag_q <= 4'h0;
		end else begin
			wr_done_q <= wr_ctrl & cmd.wr_done;
			wr_tag_q <= (wr_ctrl & cmd.wr_done) ? cmd.tag : 4'h0;
		end
	end

	// ----------------------------------------------------------------
	// observation of device outputs
	// ----------------------------------------------------------------
	logic int_any;
	assign int_any = int_rsp.accept | int_rsp.reject;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pio_q <= 64'h0;
			mmu_q <= 64'h0;
			int_id_q <= 6'h00;
			int_acc_q <= 1'b0;
			int_rej_q <= 1'b0;
			int_count_q <= 8'h00;
		end else begin
			if (pio.hdr_valid) begin
				pio_q <= pio.data;
			end
			if (pio.mmu_valid) begin
				mmu_q <= pio.data;
			end
			// id is taken only while accept or reject qualifies it
			if (int_any) begin
				int_id_q <= int_rsp.id;
				int_acc_q <= int_rsp.accept;
				int_rej_q <= int_rsp.reject;
				int_count_q <= int_count_q + 8'h01;
			end
		end
	end

	// sticky errors: a new event wins over a clear in the same cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cred_err_q <= 1'b0;
			int_err_q <= 1'b0;
		end else begin
			cred_err_q <= cred_clash | (cred_err_q & ~(wr_stat & wstat.cred_err));
			int_err_q <= (int_rsp.accept & int_rsp.reject)
				| (int_err_q & ~(wr_stat & wstat.int_err));
		end
	end

	// ----------------------------------------------------------------
	// upstream sender: request, grant, header, four payload beats
	// ----------------------------------------------------------------
	assign up_busy = (st_q != UP_IDLE);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= UP_IDLE;
			up_req_q <= 1'b0;
			up_valid_q <= 1'b0;
			up_data_q <= 32'h0000_0000;
			beat_q <= 3'h0;
		end else begin
			case (st_q)
				UP_IDLE: begin
					if (wr_ctrl && cmd.send) begin
						st_q <= UP_REQ;
						up_req_q <= 1'b1;
					end
				end
				UP_REQ: begin
					if (up_grant) begin
						st_q <= UP_SEND;
						up_req_q <= 1'b0;
						up_valid_q <= 1'b1;
						up_data_q <= hdr_out;
						beat_q <= 3'h0;
					end
				end
				UP_SEND: begin
					if (beat_q == PAY_BEATS) begin
						st_q <= UP_IDLE;
						up_valid_q <= 1'b0;
						up_data_q <= 32'h0000_0000;
					end else begin
						up_data_q <= pkt_w[beat_q[1:0]];
						beat_q <= beat_q + 3'h1;
					end
				end
				default: begin
					st_q <= UP_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// fuse link
	// ----------------------------------------------------------------
	fuse_shifter u_fuse (
		.clk(clk),
		.reset_n(reset_n),
		.start(wr_ctrl & cmd.fuse_go),
		.sel(cmd.fuse_sel),
		.word(fuse_word_q),
		.busy(fuse_busy),
		.fuse_shift_clock(fuse_shift_clock),
		.fuse_data(fuse_data),
		.fuse_strobe(fuse_strobe)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign avl_readdata = rdata_q;
	assign avl_waitrequest = wait_q;
	assign up_req = up_req_q;
	assign up_valid = up_valid_q;
	assign up_data = up_data_q;
	assign wr_done_valid = wr_done_q;
	assign wr_done_tag = wr_tag_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_grant_header: assert property (@(posedge clk) disable iff (!reset_n)
		up_start |=> up_valid_q && up_data_q == $past(hdr_out) && !up_req_q)
		else $error("header not sent right after grant");
	chk_packet_len: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(up_valid_q) |-> up_valid_q [*5] ##1 !up_valid_q)
		else $error("packet not five cycles");
	chk_ret_tag_rsvd: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(up_valid_q) && up_data_q[TAG_KIND] |-> up_data_q[14:12] == 3'h0)
		else $error("read return tag reserved bits set");
	chk_wrdone_tag: assert property (@(posedge clk) disable iff (!reset_n)
		wr_ctrl && cmd.wr_done |=> wr_done_valid && wr_done_tag == $past(cmd.tag)
		##1 !wr_done_valid || $past(wr_ctrl))
		else $error("write-done tag wrong");
	chk_ret_credit: assert property (@(posedge clk) disable iff (!reset_n)
		up_start && is_ret && !pio.hdr_valid |=> !credits_q[$past(hdr_cred)])
		else $error("returned credit still outstanding");
	chk_int_capture: assert property (@(posedge clk) disable iff (!reset_n)
		int_any |=> int_id_q == $past(int_rsp.id) && int_acc_q == $past(int_rsp.accept))
		else $error("interrupt response not captured");
endmodule : io_host_ctrl
`default_nettype wire

// [verif/far_device.sv]
`timescale 1ns/10ps
`default_nettype none
module far_device (
	// system
	input wire logic clk,
	input wire logic reset_n,
	// upstream link
	input wire logic up_req,
	output var logic up_grant,
	input wire logic up_valid,
	input wire logic [31:0] up_data,
	input wire logic [3:0] gw,
	// fuse link
	input wire logic fuse_shift_clock,
	input wire logic fuse_data,
	input wire logic [3:0] fuse_strobe,
	// observation
	output var logic [159:0] pkt,
	output var logic [63:0] fq,
	output var logic [6:0] fn,
	output var logic [7:0] errs
);
	logic [3:0] w;
	logic [2:0] beat;
	logic fc_d, st_d, gnt_d;
	// ----
	// grant after gw cycles, collect words and fuse bits
	// ----
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			{up_grant, w, beat, fc_d, st_d, gnt_d, pkt, fq, fn, errs} <= '0;
		end else begin
			fc_d <= fuse_shift_clock;
			st_d <= |fuse_strobe;
			gnt_d <= up_grant & up_req;
			up_grant <= 1'b0;
			w <= 4'h0;
			if (up_req && !up_valid && beat == 3'h0 && !up_grant) begin
				up_grant <= w >= gw;
				w <= w + 4'h1;
			end
			beat <= up_valid ? beat + 3'h1 : 3'h0;
			if (up_valid) begin
				pkt <= {up_data, pkt[159:32]};
			end
			if ((gnt_d && !up_valid) || (!up_valid && beat != 3'h0 && beat != 3'h5)
				|| $countones(fuse_strobe) > 1) begin
				errs <= errs + 8'h1;
			end
			if (|fuse_strobe && !st_d) begin
				fq <= '0;
				fn <= '0;
			end else if (fuse_shift_clock && !fc_d && |fuse_strobe) begin
				fq <= {fq[62:0], fuse_data};
				fn <= fn + 7'h1;
			end
		end
	end
endmodule : far_device
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
	import io_host_pkg::*;
	logic clk, reset_n, up_req, up_grant, up_valid, wv, fuse_shift_clock, fuse_data;
	logic avl_waitrequest;
	logic [31:0] avl_readdata, up_data, r, h;
	logic [3:0] wt, dt, fuse_strobe, gw;
	logic [159:0] pkt;
	logic [63:0] fq;
	logic [6:0] fn;
	logic [7:0] errs;
	avl_req_s avl;
	pio_bus_s pio;
	int_rsp_s int_rsp;
	ctl_pkt_s p, e;
	int mismatches = 0, checked = 0, cyc = 0;
	logic [3:0] codes [7] = '{PT_RD_REJ, PT_RD_ACK, PT_FL_ACK, PT_FL_REJ, PT_RD_REQ,
		PT_WR_REQ, PT_FL_REQ};
	io_host_ctrl dut (.clk(clk), .reset_n(reset_n), .avl(avl), .avl_readdata(avl_readdata),
		.avl_waitrequest(avl_waitrequest), .up_req(up_req), .up_grant(up_grant),
		.up_valid(up_valid), .up_data(up_data), .pio(pio), .wr_done_valid(wv),
		.wr_done_tag(wt), .int_rsp(int_rsp), .fuse_shift_clock(fuse_shift_clock),
		.fuse_data(fuse_data), .fuse_strobe(fuse_strobe));
	far_device dev (.clk(clk), .reset_n(reset_n), .up_req(up_req), .up_grant(up_grant),
		.up_valid(up_valid), .up_data(up_data), .gw(gw), .fuse_shift_clock(fuse_shift_clock),
		.fuse_data(fuse_data), .fuse_strobe(fuse_strobe), .pkt(pkt), .fq(fq), .fn(fn),
		.errs(errs));
	// ----
	// helpers
	// ----
	task chk(input logic [63:0] s, input logic [63:0] x);
		checked++;
		if (s !== x) begin
			mismatches++;
			$display("mismatch %0t seen %h want %h", $time, s, x);
		end
	endtask : chk
	task acc(input logic rd, input logic [3:0] a, input logic [31:0] d);
		avl <= '{rd, ~rd, {a, 2'b00}, d};
		@(posedge clk);
		while (avl_waitrequest !== 1'b0) @(posedge clk);
		r = avl_readdata;
		avl <= '0;
		@(posedge clk);
	endtask : acc
	task rc(input logic [3:0] a, input logic [31:0] x);
		acc(1'b1, a, 32'h0);
		chk(r, x);
	endtask : rc
	task ph(input logic m, input logic [63:0] d);
		pio <= '{~m, m, d};
		@(posedge clk);
		pio <= '{1'b0, 1'b0, ~d};
	endtask : ph
	task ir(input logic a, input logic j, input logic [5:0] id);
		int_rsp <= '{a, j, id};
		@(posedge clk);
		int_rsp <= '{1'b0, 1'b0, ~id};
	endtask : ir
	task test_done;
		if (mismatches == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (wv === 1'b1)
			dt <= wt;
		if (cyc == 30000) begin
			mismatches++;
			test_done();
		end
	end
	initial begin
		reset_n = 1'b0;
		avl = '0;
		pio = '0;
		int_rsp = '0;
		gw = 4'h0;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rc(REG_STATUS, 32'h0);
		rc(REG_CREDITS, 32'h0);
		acc(1'b0, 4'hE, 32'hFFFF_FFFF);
		rc(4'hE, 32'h0);
		ph(1'b0, 64'h1900_0000_CAFE_0001);
		rc(REG_CREDITS, 32'h200);
		rc(REG_PIO_HI, 32'h1900_0000);
		ph(1'b0, 64'h1900_0000_CAFE_0001);
		rc(REG_STATUS, 32'h4);
		acc(1'b0, REG_STATUS, 32'h4);
		acc(1'b0, REG_CTRL, 32'h92);
		rc(REG_CREDITS, 32'h0);
		chk(dt, 4'h9);
		rc(REG_STATUS, 32'h0);
		ph(1'b1, 64'h0123_4567_89AB_CDEF);
		rc(REG_MMU_LO, 32'h89AB_CDEF);
		rc(REG_MMU_HI, 32'h0123_4567);
		ph(1'b0, 64'h1900_0000_0000_0000);
		for (int i = 0; i < 7; i++) begin
			p = {64'h1122_3344_5566_7788, 9'h1FF, 40'hAB_CDEF_0123, SZ_8B,
				i[0] ? BUF_TEST : BUF_CORE, 3'h5, 3'h2, codes[i]};
			h = i[0] ? 32'h7FFF_7F5C : 32'h0FC0_F9AB;
			e = p;
			if (codes[i] inside {PT_RD_REJ, PT_FL_REJ})
				e.payload = '0;
			if (!codes[i][2] || codes[i] == PT_FL_REJ) begin
				e.hdr.addr = '0;
				e.hdr.size = '0;
			end
			if (!i[0])
				e.hdr.byte_sel = '0;
			gw <= i[3:0];
			acc(1'b0, REG_HDR, h);
			for (int k = 0; k < 4; k++)
				acc(1'b0, 4'(REG_PAY0 + k), p[32*k +: 32]);
			acc(1'b0, REG_CTRL, 32'h1);
			while (up_valid !== 1'b1) @(posedge clk);
			while (up_valid !== 1'b0) @(posedge clk);
			chk(up_data, 32'h0);
			chk(pkt[31:0], h & HDR_RSVD_MASK & (h[15] ? HDR_RET_MASK : HDR_INT_MASK));
			chk(pkt[159:96], e[127:64]);
			chk(pkt[95:32], e[63:0]);
		end
		rc(REG_CREDITS, 32'h0);
		ir(1'b1, 1'b0, 6'h3E);
		rc(REG_STATUS, 32'h0001_3E10);
		ir(1'b0, 1'b1, 6'h15);
		rc(REG_STATUS, 32'h0002_1520);
		ir(1'b1, 1'b1, 6'h01);
		acc(1'b1, REG_STATUS, 32'h0);
		chk(r[3], 1'b1);
		acc(1'b0, REG_FUSE_LO, 32'hDEAD_BEEF);
		acc(1'b0, REG_FUSE_HI, 32'h1234_5678);
		for (int s = 0; s < 4; s++) begin
			acc(1'b0, REG_CTRL, {20'h0, s[1:0], 10'h4});
			while (fuse_strobe === 4'h0) @(posedge clk);
			chk(fuse_strobe, 4'h1 << s);
			while (fuse_strobe !== 4'h0) @(posedge clk);
			chk(fn, s == 3 ? 7'h40 : 7'h16);
			chk(fq, s == 3 ? 64'h1234_5678_DEAD_BEEF : 64'h2D_BEEF);
		end
		chk(errs, 8'h0);
		test_done();
	end
endmodule : tb
`default_nettype wire
